/* File: verilog/spi_flags_pkg.sv */
// Constants, field positions and carrier types for the serial data-path block.
package spi_flags_pkg;

	// -----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// -----------------------------------------------------------------
	localparam logic [7:0] IDX_INT_CTRL   = 8'h02;
	localparam logic [7:0] IDX_INT_FLAGS  = 8'h03;
	localparam logic [7:0] IDX_DATA       = 8'h04;
	localparam logic [7:0] IDX_LINK_CFG   = 8'h05;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_INT_CTRL   = 8'h00;
	localparam logic [7:0] RST_INT_FLAGS  = 8'h00;
	localparam logic [7:0] RST_DATA       = 8'h00;
	localparam logic [7:0] RST_LINK_CFG   = 8'h00;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int BIT_RX_DONE    = 7;
	localparam int BIT_TX_DONE    = 6;
	localparam int BIT_TX_EMPTY   = 5;
	localparam int BIT_SEL_FALL   = 4;
	localparam int BIT_GENERAL_EN = 0;
	localparam int BIT_BYTE_DONE  = 7;
	localparam int BIT_WR_COLL    = 6;
	localparam int BIT_RX_OVF     = 0;
	localparam int BIT_CFG_ENABLE = 0;
	localparam int BIT_CFG_HOST   = 1;
	localparam int BIT_CFG_SELDIS = 2;
	localparam int BIT_CFG_BUFFERED_MODE_EN  = 7;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int SCK_HALF_NS    = 40;
	localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
	                                / CLK_PERIOD_NS;
	localparam int BYTE_BITS      = 8;

	// -----------------------------------------------------------------
	// Carrier types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic       buffered_mode_en;
		logic [3:0] unused;
		logic       select_disable;
		logic       host_mode;
		logic       enable;
	} link_cfg_t;

	typedef struct packed {
		logic rx_done_irq_en;
		logic tx_done_irq_en;
		logic tx_empty_irq_en;
		logic select_fallback_irq_en;
		logic general_irq_en;
	} irq_en_t;

	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_LOW,
		HOST_HIGH
	} host_state_t;

endpackage

/* File: verilog/spi_flags_data_path.sv */
// Interrupt flags, enables and data access of a byte serial link, APB slave.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
// Function
// - Receive-done enable gates flag; zero unbuffered.
// - Transfer-done enable gates flag; zero unbuffered.
// - Transmit-empty enable gates flag; zero unbuffered.
// - Select-fallback enable gates flag; zero unbuffered.
// - General enable gates byte-done flag unbuffered.
// - Byte-done flag sets after each byte unbuffered.
// - Select fall as host sets byte-done unbuffered.
// - Byte-done clears on one or read-then-access.
// - Data write while shifting sets collision flag unbuffered.
// - Collision clears on flag read then access.
// - Receive-done follows buffer fill; one clears.
// - Transfer-done sets when shifter and buffer empty.
// - Transmit-empty high until data write.
// - Select-fallback sets on forced client; one clears.
// - Overflow sets on third byte, buffers full.
// - Overflow needs a real transfer to start.
// - Overflow clears on data read or one.
// - Data write starts host, stages client.
// - Unbuffered data hits shifter and receive register.
// - Buffered data uses transmit and receive buffers.
// - Request stands while flag and enable set.
// - Buffer mode enable selects buffered operation.
// - Select fall as host clears host bit.
module spi_flags_data_path
	import spi_flags_pkg::*;
#(
	parameter int HALF_CYC = SCK_HALF_CYC
)(
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             IRQ,
	input  wire logic        SCK_I,
	output logic             SCK_O,
	output logic             SCK_OE,
	input  wire logic        MOSI_I,
	output logic             MOSI_O,
	output logic             MOSI_OE,
	input  wire logic        MISO_I,
	output logic             MISO_O,
	output logic             MISO_OE,
	input  wire logic        SEL_N_I
);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [3:0]  sync1_q;
	logic [3:0]  sync2_q;
	logic        sck_s;
	logic        mosi_s;
	logic        miso_s;
	logic        sel_n_s;
	logic        sck_prev_q;
	logic        sel_prev_q;

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sync1_q    <= 4'h1;
			sync2_q    <= 4'h1;
			sck_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end
		else
		begin
			sync1_q    <= {SCK_I, MOSI_I, MISO_I, SEL_N_I};
			sync2_q    <= sync1_q;
			sck_prev_q <= sck_s;
			sel_prev_q <= sel_n_s;
		end
	end

	assign sck_s   = sync2_q[3];
	assign mosi_s  = sync2_q[2];
	assign miso_s  = sync2_q[1];
	assign sel_n_s = sync2_q[0];

	// -----------------------------------------------------------------
	// Register bus decode
	// -----------------------------------------------------------------
	link_cfg_t   cfg_q;
	irq_en_t     en_q;
	logic        buf_mode;
	logic        access;
	logic        wr_acc;
	logic        rd_acc;
	logic [7:0]  idx;
	logic        mapped;
	logic        wr_en;
	logic        wr_flags;
	logic        wr_data;
	logic        wr_cfg;
	logic        rd_flags;
	logic        rd_data;
	logic        acc_data;
	logic [7:0]  wbyte;

	assign buf_mode = cfg_q.buffered_mode_en;
	assign access   = PSEL & PENABLE;
	assign wr_acc   = access & PWRITE;
	assign rd_acc   = access & ~PWRITE;
	assign idx      = {2'h0, PADDR[7:2]};
	assign mapped   = (PADDR[11:8] == 4'h0) && (PADDR[1:0] == 2'h0)
	                  && (idx == IDX_INT_CTRL || idx == IDX_INT_FLAGS
	                  || idx == IDX_DATA || idx == IDX_LINK_CFG);
	assign wr_en    = wr_acc & (idx == IDX_INT_CTRL) & mapped;
	assign wr_flags = wr_acc & (idx == IDX_INT_FLAGS) & mapped;
	assign wr_data  = wr_acc & (idx == IDX_DATA) & mapped;
	assign wr_cfg   = wr_acc & (idx == IDX_LINK_CFG) & mapped;
	assign rd_flags = rd_acc & (idx == IDX_INT_FLAGS) & mapped;
	assign rd_data  = rd_acc & (idx == IDX_DATA) & mapped;
	assign acc_data = wr_data | rd_data;
	assign wbyte    = PWDATA[7:0];
	assign PREADY   = 1'b1;
	assign PSLVERR  = access & ~mapped;

	// -----------------------------------------------------------------
	// Shift engine state
	// -----------------------------------------------------------------
	host_state_t hst_q;
	logic [7:0]  shift_q;
	logic [2:0]  bits_q;
	logic [15:0] div_q;
	logic        busy;
	logic        host_act;
	logic        client_act;
	logic        byte_done;
	logic        host_start;
	logic        load_shift;
	logic [7:0]  load_val;
	logic        sel_fall;
	logic        fallback;
	logic        div_end;

	// Buffers and flags.
	logic [7:0]  tx_buf_q;
	logic        tx_full_q;
	logic [7:0]  rx_data_q;
	logic [7:0]  rx_buf_q;
	logic [1:0]  rx_cnt_q;
	logic        rx_hide_q;
	logic        byte_flag_q;
	logic        coll_flag_q;
	logic        tx_done_q;
	logic        sel_flag_q;
	logic        ovf_q;
	logic        arm_byte_q;
	logic        arm_coll_q;
	logic        rx_done_flag;
	logic        tx_empty_flag;

	assign host_act   = cfg_q.enable & cfg_q.host_mode;
	assign client_act = cfg_q.enable & ~cfg_q.host_mode & ~sel_n_s;
	assign busy       = (hst_q != HOST_IDLE) || (client_act && bits_q != 3'h0);
	assign div_end    = (div_q == 16'(HALF_CYC - 1));
	assign sel_fall   = sel_prev_q & ~sel_n_s;
	assign fallback   = sel_fall & host_act & ~cfg_q.select_disable;

	// Client samples on the synced rising edge; the last one ends the byte.
	assign byte_done = (hst_q == HOST_HIGH && div_end && bits_q == 3'h7)
	                   || (client_act && ~sck_prev_q && sck_s
	                       && bits_q == 3'h7);

	// Unbuffered writes go straight into an idle shifter; buffered writes wait.
	always_comb
	begin
		load_shift = 1'b0;
		load_val   = tx_buf_q;
		if (!buf_mode && wr_data && !busy)
		begin
			load_shift = 1'b1;
			load_val   = wbyte;
		end
		else if (buf_mode && tx_full_q && !busy && !byte_done)
		begin
			load_shift = 1'b1;
		end
	end

	assign host_start = load_shift & host_act;

	// -----------------------------------------------------------------
	// Host clock generator and bit engine
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			hst_q <= HOST_IDLE;
			div_q <= 16'h0;
		end
		else
		begin
			case (hst_q)
				HOST_IDLE:
				begin
					div_q <= 16'h0;
					if (host_start)
						hst_q <= HOST_LOW;
				end
				HOST_LOW:
				begin
					div_q <= div_end ? 16'h0 : div_q + 16'h1;
					if (!host_act)
						hst_q <= HOST_IDLE;
					else if (div_end)
						hst_q <= HOST_HIGH;
				end
				HOST_HIGH:
				begin
					div_q <= div_end ? 16'h0 : div_q + 16'h1;
					if (div_end)
						hst_q <= (bits_q == 3'h7) ? HOST_IDLE : HOST_LOW;
				end
				default:
				begin
					hst_q <= HOST_IDLE;
				end
			endcase
		end
	end

	// Bits shift MSB first; a client without a frame holds no partial byte.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			shift_q <= RST_DATA;
			bits_q  <= 3'h0;
		end
		else if (load_shift)
		begin
			shift_q <= load_val;
			bits_q  <= 3'h0;
		end
		else if (hst_q == HOST_HIGH && div_end)
		begin
			shift_q <= {shift_q[6:0], miso_s};
			bits_q  <= bits_q + 3'h1;
		end
		else if (client_act && ~sck_prev_q && sck_s)
		begin
			shift_q <= {shift_q[6:0], mosi_s};
			bits_q  <= bits_q + 3'h1;
		end
		else if (!host_act && sel_n_s)
		begin
			bits_q <= 3'h0;
		end
	end

	assign SCK_O   = (hst_q == HOST_HIGH);
	assign SCK_OE  = host_act;
	assign MOSI_O  = shift_q[7];
	assign MOSI_OE = host_act;
	assign MISO_O  = shift_q[7];
	assign MISO_OE = client_act;

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			cfg_q <= link_cfg_t'(RST_LINK_CFG);
			en_q  <= irq_en_t'(5'h0);
		end
		else
		begin
			if (wr_cfg)
			begin
				cfg_q.buffered_mode_en <= wbyte[BIT_CFG_BUFFERED_MODE_EN];
				cfg_q.select_disable   <= wbyte[BIT_CFG_SELDIS];
				cfg_q.host_mode        <= wbyte[BIT_CFG_HOST];
				cfg_q.enable           <= wbyte[BIT_CFG_ENABLE];
			end
			else if (fallback)
			begin
				cfg_q.host_mode <= 1'b0;
			end
			if (wr_en)
			begin
				en_q.rx_done_irq_en         <= wbyte[BIT_RX_DONE];
				en_q.tx_done_irq_en         <= wbyte[BIT_TX_DONE];
				en_q.tx_empty_irq_en        <= wbyte[BIT_TX_EMPTY];
				en_q.select_fallback_irq_en <= wbyte[BIT_SEL_FALL];
				en_q.general_irq_en         <= wbyte[BIT_GENERAL_EN];
			end
		end
	end

	// -----------------------------------------------------------------
	// Transmit buffer
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			tx_buf_q  <= RST_DATA;
			tx_full_q <= 1'b0;
		end
		else if (buf_mode && wr_data)
		begin
			tx_buf_q  <= wbyte;
			tx_full_q <= 1'b1;
		end
		else if (load_shift || !buf_mode)
		begin
			tx_full_q <= 1'b0;
		end
	end

	assign tx_empty_flag = ~tx_full_q;

	// -----------------------------------------------------------------
	// Receive path: a two-deep buffer in buffered mode
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			rx_data_q <= RST_DATA;
			rx_buf_q  <= RST_DATA;
			rx_cnt_q  <= 2'h0;
			rx_hide_q <= 1'b0;
		end
		else if (!buf_mode)
		begin
			rx_cnt_q  <= 2'h0;
			rx_hide_q <= 1'b0;
			if (byte_done)
				rx_data_q <= {shift_q[6:0], host_act ? miso_s : mosi_s};
		end
		else
		begin
			if (wr_flags && wbyte[BIT_RX_DONE])
				rx_hide_q <= 1'b1;
			if (byte_done && rx_cnt_q != 2'h2)
				rx_hide_q <= 1'b0;
			// A read pops the front entry; the second one moves up.
			if (rd_data && rx_cnt_q != 2'h0)
			begin
				rx_buf_q <= rx_data_q;
				if (byte_done)
					rx_data_q <= {shift_q[6:0], host_act ? miso_s : mosi_s};
				else
					rx_cnt_q <= rx_cnt_q - 2'h1;
			end
			else if (byte_done && rx_cnt_q == 2'h0)
			begin
				rx_buf_q <= {shift_q[6:0], host_act ? miso_s : mosi_s};
				rx_cnt_q <= 2'h1;
			end
			else if (byte_done && rx_cnt_q == 2'h1)
			begin
				rx_data_q <= {shift_q[6:0], host_act ? miso_s : mosi_s};
				rx_cnt_q  <= 2'h2;
			end
		end
	end

	assign rx_done_flag = (rx_cnt_q != 2'h0) & ~rx_hide_q;

	// -----------------------------------------------------------------
	// Flags: a set in the same cycle as a clear wins, except that a data read beats an overflow set
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			byte_flag_q <= 1'b0;
			coll_flag_q <= 1'b0;
			arm_byte_q  <= 1'b0;
			arm_coll_q  <= 1'b0;
		end
		else
		begin
			if (rd_flags)
			begin
				arm_byte_q <= byte_flag_q;
				arm_coll_q <= coll_flag_q;
			end
			else if (acc_data)
			begin
				arm_byte_q <= 1'b0;
				arm_coll_q <= 1'b0;
			end
			if ((wr_flags && wbyte[BIT_BYTE_DONE] && !buf_mode)
			    || (acc_data && arm_byte_q))
				byte_flag_q <= 1'b0;
			if (!buf_mode && (byte_done || fallback))
				byte_flag_q <= 1'b1;
			if (acc_data && arm_coll_q)
				coll_flag_q <= 1'b0;
			if (!buf_mode && wr_data && busy)
				coll_flag_q <= 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			tx_done_q  <= 1'b0;
			sel_flag_q <= 1'b0;
			ovf_q      <= 1'b0;
		end
		else
		begin
			if (wr_flags && wbyte[BIT_TX_DONE])
				tx_done_q <= 1'b0;
			if (buf_mode && byte_done && !tx_full_q)
				tx_done_q <= 1'b1;
			if (wr_flags && wbyte[BIT_SEL_FALL])
				sel_flag_q <= 1'b0;
			if (buf_mode && fallback)
				sel_flag_q <= 1'b1;
			if (rd_data || (wr_flags && wbyte[BIT_RX_OVF]))
				ovf_q <= 1'b0;
			// A byte only completes after its transfer began on the wire.
			if (buf_mode && byte_done && rx_cnt_q == 2'h2 && !rd_data)
				ovf_q <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Read data, captured in the setup cycle
	// -----------------------------------------------------------------
	logic [7:0] rbyte;

	always_comb
	begin
		rbyte = 8'h00;
		case (idx)
			IDX_INT_CTRL:
			begin
				rbyte[BIT_RX_DONE]    = buf_mode & en_q.rx_done_irq_en;
				rbyte[BIT_TX_DONE]    = buf_mode & en_q.tx_done_irq_en;
				rbyte[BIT_TX_EMPTY]   = buf_mode & en_q.tx_empty_irq_en;
				rbyte[BIT_SEL_FALL]   = buf_mode
				                        & en_q.select_fallback_irq_en;
				rbyte[BIT_GENERAL_EN] = en_q.general_irq_en;
			end
			IDX_INT_FLAGS:
			begin
				if (buf_mode)
				begin
					rbyte[BIT_RX_DONE]  = rx_done_flag;
					rbyte[BIT_TX_DONE]  = tx_done_q;
					rbyte[BIT_TX_EMPTY] = tx_empty_flag;
					rbyte[BIT_SEL_FALL] = sel_flag_q;
					rbyte[BIT_RX_OVF]   = ovf_q;
				end
				else
				begin
					rbyte[BIT_BYTE_DONE] = byte_flag_q;
					rbyte[BIT_WR_COLL]   = coll_flag_q;
				end
			end
			IDX_DATA:
			begin
				rbyte = buf_mode ? rx_buf_q : rx_data_q;
			end
			IDX_LINK_CFG:
			begin
				rbyte = cfg_q;
			end
			default:
			begin
				rbyte = 8'h00;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			PRDATA <= 32'h0;
		else if (PSEL && !PENABLE && !PWRITE)
			PRDATA <= {24'h0, mapped ? rbyte : 8'h00};
	end

	// -----------------------------------------------------------------
	// Interrupt output
	// -----------------------------------------------------------------
	always_comb
	begin
		if (buf_mode)
			IRQ = (rx_done_flag & en_q.rx_done_irq_en)
			    | (tx_done_q & en_q.tx_done_irq_en)
			    | (tx_empty_flag & en_q.tx_empty_irq_en)
			    | (sel_flag_q & en_q.select_fallback_irq_en);
		else
			IRQ = byte_flag_q & en_q.general_irq_en;
	end

endmodule

/* File: verification/spi_flags_data_path_checker.sv */
// Port-level assertions for the serial data-path block.
`timescale 1ns/1ps
module spi_flags_data_path_checker
	import spi_flags_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        IRQ,
	input wire logic        SCK_O,
	input wire logic        SCK_OE,
	input wire logic        MOSI_OE,
	input wire logic        SEL_N_I
);
	logic       wr;
	logic [7:0] ctrl_q;
	logic [7:0] cfg_q;

	// -----------------------------------------------------------------
	// Shadows of the control registers.
	// -----------------------------------------------------------------
	assign wr = PSEL && PENABLE && PREADY && PWRITE;

	always_ff @(posedge CLK or posedge RESET)
		if (RESET)
			ctrl_q <= 8'h00;
		else if (wr && PADDR == 12'h008)
			ctrl_q <= PWDATA[7:0];

	// The shadow misses the host bit being dropped by the select pin.
	always_ff @(posedge CLK or posedge RESET)
		if (RESET)
			cfg_q <= 8'h00;
		else if (wr && PADDR == 12'h014)
			cfg_q <= PWDATA[7:0];

	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	sequence s_data_wr;
		wr && PADDR == 12'h010 && SCK_OE;
	endsequence
	sequence s_sck_rise;
		##[1:40] $rose(SCK_O);
	endsequence

	property p_host_start;
		s_data_wr |-> s_sck_rise;
	endproperty
	property p_unbuf_gate;
		(!cfg_q[7] && !ctrl_q[0]) |-> !IRQ;
	endproperty
	property p_buf_gate;
		(cfg_q[7] && ctrl_q[7:4] == 4'h0) |-> !IRQ;
	endproperty
	property p_irq_hold;
		(IRQ && !PSEL) |=> IRQ;
	endproperty
	property p_flag_w1c;
		(wr && PADDR == 12'h00c && PWDATA[7] && !cfg_q[7]) |=> !IRQ;
	endproperty
	property p_cfg_oe;
		(wr && PADDR == 12'h014 && SEL_N_I)
			|=> SCK_OE == ($past(PWDATA[0]) && $past(PWDATA[1]));
	endproperty
	property p_mosi_oe;
		MOSI_OE == SCK_OE;
	endproperty
	property p_fallback;
		($fell(SEL_N_I) && SCK_OE && !cfg_q[2]) |-> ##[1:6] !SCK_OE;
	endproperty
	property p_seldis;
		(!SEL_N_I && cfg_q[2] && SCK_OE && !PSEL) |=> SCK_OE;
	endproperty

	a_host_start: assert property (p_host_start)
		else $error("host byte did not start");
	a_unbuf_gate: assert property (p_unbuf_gate)
		else $error("request without general enable");
	a_buf_gate: assert property (p_buf_gate)
		else $error("buffered request without enable");
	a_irq_hold: assert property (p_irq_hold)
		else $error("request dropped without access");
	a_flag_w1c: assert property (p_flag_w1c)
		else $error("byte flag survived write one");
	a_cfg_oe: assert property (p_cfg_oe)
		else $error("clock drive does not follow host bit");
	a_mosi_oe: assert property (p_mosi_oe)
		else $error("data out drive differs from clock drive");
	a_fallback: assert property (p_fallback)
		else $error("host kept after select fell");
	a_seldis: assert property (p_seldis)
		else $error("host lost with select disabled");
endmodule

bind spi_flags_data_path spi_flags_data_path_checker
	spi_flags_data_path_checker_i (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PREADY(PREADY), .IRQ(IRQ), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
	.MOSI_OE(MOSI_OE), .SEL_N_I(SEL_N_I));

/* File: verification/spi_client_model.sv */
// Far-end client of the serial link, mode 0, most significant bit first.
`timescale 1ns/1ps
module spi_client_model
(
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic [7:0] reply,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] tx_q;
	logic       mosi_d;
	int         cnt;

	// A small delay keeps the sample clear of data changing at the edge.
	assign #1 mosi_d = mosi;
	assign miso = (cnt == 0) ? reply[7] : tx_q[7];

	initial
	begin
		cnt = 0;
		got = 8'h00;
		tx_q = 8'h00;
	end

	always @(posedge sck)
	begin
		if (cnt == 0)
			tx_q = reply;
		got = {got[6:0], mosi_d};
		cnt = cnt + 1;
	end

	// The count wraps on the falling edge so the last bit stays on the line.
	always @(negedge sck)
		if (cnt == 8)
			cnt = 0;
		else if (cnt != 0)
			tx_q = {tx_q[6:0], 1'b0};
endmodule

/* File: verification/testbench.sv */
// Register-level tests of the serial data-path block against a client.
`timescale 1ns/1ps
module testbench;
	import spi_flags_pkg::*;

	logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_n;
	logic        part_miso, sck_h, mosi_h;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  reply, got, rdata, crx;
	logic        serr;
	int          num_errors, num_checks;
	wire logic   sck_w = sck_oe ? sck_o : sck_h;
	wire logic   mosi_w = mosi_oe ? mosi_o : mosi_h;
	wire logic   miso_w = miso_oe ? miso_o : part_miso;

	spi_flags_data_path #(.HALF_CYC(16)) spi_flags_data_path_i (.CLK(clk),
		.RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o),
		.SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
		.MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
		.MISO_OE(miso_oe), .SEL_N_I(sel_n));
	spi_client_model spi_client_model_i (.sck(sck_w), .mosi(mosi_w),
		.reply(reply), .miso(part_miso), .got(got));

	always #2.5 clk = ~clk;

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the trailing idle edge keeps requests apart.
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		rdata = prdata[7:0];
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 8'h01, {7'h00, pready});
		if (pready !== 1'b1)
			results();
		@(posedge clk);
	endtask

	task automatic rchk(input string name, input logic [7:0] idx,
		input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(name, exp, rdata);
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400)
		begin
			n++;
			@(posedge clk);
		end
		chk("irq", 8'h01, {7'h00, irq});
		if (irq !== 1'b1)
			results();
	endtask

	task automatic poll(input int b);
		int n;
		n = 0;
		rdata = 8'h00;
		while (rdata[b] !== 1'b1 && n < 200)
		begin
			n++;
			apb(1'b0, IDX_INT_FLAGS, 8'h00);
		end
		chk("poll", 8'h01, {7'h00, rdata[b]});
		if (rdata[b] !== 1'b1)
			results();
	endtask

	// Plays a far host for one byte, mode 0, MSB first, 160 ns per bit.
	task automatic host_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			mosi_h <= tx[i];
			repeat (16) @(posedge clk);
			sck_h <= 1'b1;
			rx[i] = miso_o;
			repeat (16) @(posedge clk);
			sck_h <= 1'b0;
		end
	endtask

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		reply = 8'h00;
		sel_n = 1'b1;
		sck_h = 1'b0;
		mosi_h = 1'b0;
		num_errors = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk("ctrl", IDX_INT_CTRL, RST_INT_CTRL);
		rchk("flags", IDX_INT_FLAGS, RST_INT_FLAGS);
		rchk("data", IDX_DATA, RST_DATA);
		apb(1'b0, 8'h07, 8'h00);
		chk("slverr", 8'h01, {7'h00, serr});
		apb(1'b1, IDX_INT_CTRL, 8'hf1);
		rchk("ctrl", IDX_INT_CTRL, 8'h01);
		apb(1'b1, IDX_LINK_CFG, 8'h80);
		rchk("ctrl", IDX_INT_CTRL, 8'hf1);
		chk("irq", 8'h01, {7'h00, irq});
		rchk("flags", IDX_INT_FLAGS, 8'h20);
		apb(1'b1, IDX_INT_CTRL, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		$display("test registers done");

		apb(1'b1, IDX_LINK_CFG, 8'h03);
		apb(1'b1, IDX_INT_CTRL, 8'h01);
		reply <= 8'ha5;
		apb(1'b1, IDX_DATA, 8'h3c);
		apb(1'b1, IDX_DATA, 8'h55);
		wait_irq();
		chk("sent", 8'h3c, got);
		rchk("flags", IDX_INT_FLAGS, 8'hc0);
		rchk("data", IDX_DATA, 8'ha5);
		rchk("flags", IDX_INT_FLAGS, 8'h00);
		reply <= 8'h18;
		apb(1'b1, IDX_DATA, 8'h81);
		wait_irq();
		apb(1'b1, IDX_INT_FLAGS, 8'h80);
		chk("irq", 8'h00, {7'h00, irq});
		rchk("data", IDX_DATA, 8'h18);
		chk("sent", 8'h81, got);
		$display("test unbuffered done");

		apb(1'b1, IDX_LINK_CFG, 8'h83);
		apb(1'b1, IDX_INT_CTRL, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			reply <= 8'h11 << i;
			apb(1'b1, IDX_DATA, 8'h5a);
			poll(BIT_TX_DONE);
			apb(1'b1, IDX_INT_FLAGS, 8'h40);
		end
		rchk("flags", IDX_INT_FLAGS, 8'ha1);
		apb(1'b1, IDX_INT_CTRL, 8'h80);
		chk("irq", 8'h01, {7'h00, irq});
		rchk("data", IDX_DATA, 8'h11);
		rchk("flags", IDX_INT_FLAGS, 8'ha0);
		rchk("data", IDX_DATA, 8'h22);
		rchk("flags", IDX_INT_FLAGS, 8'h20);
		chk("irq", 8'h00, {7'h00, irq});
		$display("test buffered done");

		apb(1'b1, IDX_INT_CTRL, 8'h10);
		sel_n <= 1'b0;
		wait_irq();
		rchk("cfg", IDX_LINK_CFG, 8'h81);
		rchk("flags", IDX_INT_FLAGS, 8'h30);
		sel_n <= 1'b1;
		apb(1'b1, IDX_INT_FLAGS, 8'h10);
		chk("irq", 8'h00, {7'h00, irq});
		apb(1'b1, IDX_LINK_CFG, 8'h87);
		sel_n <= 1'b0;
		repeat (10) @(posedge clk);
		rchk("flags", IDX_INT_FLAGS, 8'h20);
		rchk("cfg", IDX_LINK_CFG, 8'h87);
		sel_n <= 1'b1;
		$display("test select done");

		apb(1'b1, IDX_LINK_CFG, 8'h03);
		sel_n <= 1'b0;
		repeat (8) @(posedge clk);
		rchk("flags", IDX_INT_FLAGS, 8'h80);
		rchk("cfg", IDX_LINK_CFG, 8'h01);
		apb(1'b1, IDX_DATA, 8'hc3);
		host_byte(8'h96, crx);
		chk("client", 8'hc3, crx);
		rchk("flags", IDX_INT_FLAGS, 8'h80);
		rchk("data", IDX_DATA, 8'h96);
		sel_n <= 1'b1;
		$display("test client done");
		results();
	end
endmodule
